// *** hw/otu_top.sv ***
/*
 * otu_top: overlay timing unit - timing generator plus two-plane mixer
 * with base, border and crop handling, and output routing to one
 * display transmitter.
 * Assumes the upstream pipe answers a pixel request in the same cycle
 * and that software reaches the registers over classic Wishbone.
 */
// The implementer's own choices: the placing of the registers and register access over Wishbone.
`default_nettype none

// Overview of operation
// - frame height equals programmed frame line total
// - line length equals programmed line pixel total
// - hsync between programmed start and end pixels
// - vsync between programmed start and end lines
// - timing requests upstream pixels, forwards them out
// - each plane fills its programmed canvas window
// - at most one video and one graphics plane
// - graphics alpha per pixel or global; video global
// - option inverts alpha sense
// - border below each plane, selected without blending
// - video and graphics planes can be cropped
// - blending happens in IPT or RGB domain
// - normal blend: alpha fg plus inverse bg
// - premultiplied blend: fg plus weighted bg
// - base and borders are register solid colours
// - three 3-bit layer selectors over base layer
module otu_top
	import otu_pkg::*;
(
	// clock and reset
	input  wire logic          sys_clk,
	input  wire logic          rstn,
	// wishbone slave
	input  wire logic          wb_cyc_i,
	input  wire logic          wb_stb_i,
	input  wire logic          wb_we_i,
	input  wire logic [7:0]    wb_adr_i,
	input  wire logic [3:0]    wb_sel_i,
	input  wire logic [31:0]   wb_dat_i,
	output logic      [31:0]   wb_dat_o,
	output logic               wb_ack_o,
	// main video plane stream from the pipe
	output logic               vidReq,
	input  wire logic [PW-1:0] vidPix,
	// graphics plane stream from the pipe, alpha on its own gfxAlpha port
	output logic               gfxReq,
	input  wire logic [PW-1:0] gfxPix,
	input  wire logic [AW-1:0] gfxAlpha,
	// hdmi transmitter side
	output logic      [PW-1:0] hdmiPix,
	output logic               hdmiDe,
	output logic               hdmiHs,
	output logic               hdmiVs,
	// mipi transmitter side
	output logic      [PW-1:0] mipiPix,
	output logic               mipiDe,
	output logic               mipiHs,
	output logic               mipiVs
);

	// ----------------------------------------------------------------
	// register file
	// ----------------------------------------------------------------
	logic [CTRL_W-1:0] ctrl_q;
	logic [31:0]       htot_q, vtot_q, hsyn_q, vsyn_q;
	logic [31:0]       vidX_q, vidY_q, gfxX_q, gfxY_q;
	logic [31:0]       vcX_q, vcY_q, gcX_q, gcY_q;
	logic [31:0]       alpha_q, layer_q;
	logic [31:0]       baseCol_q, cbrdCol_q, vbrdCol_q, gbrdCol_q;
	logic              ack_q;
	logic [31:0]       rdat_q;

	// byte-lane merge for writes
	function automatic logic [31:0] lanes(input logic [31:0] old,
		input logic [31:0] nw, input logic [3:0] sel);
		for (int b = 0; b < 4; b++)
			lanes[b*8 +: 8] = sel[b] ? nw[b*8 +: 8] : old[b*8 +: 8];
	endfunction

	// start and end fields of a packed pair register
	function automatic logic [CW-1:0] lo(input logic [31:0] r);
		lo = r[LO_POS +: CW];
	endfunction

	function automatic logic [CW-1:0] hi(input logic [31:0] r);
		hi = r[HI_POS +: CW];
	endfunction

	wire logic busReq  = wb_cyc_i && wb_stb_i && !ack_q;
	wire logic busWr   = busReq && wb_we_i;
	wire logic [7:0] a = wb_adr_i;

	// ack one cycle after the request, dropped the cycle after
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn)
			ack_q <= 1'b0;
		else
			ack_q <= busReq;
	end

	// register writes
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			ctrl_q    <= '0;
			htot_q    <= 32'(LINE_PIXEL_TOTAL_RST);
			vtot_q    <= 32'(FRAME_LINE_TOTAL_RST);
			hsyn_q    <= '0;
			vsyn_q    <= '0;
			vidX_q    <= '0;
			vidY_q    <= '0;
			gfxX_q    <= '0;
			gfxY_q    <= '0;
			vcX_q     <= '0;
			vcY_q     <= '0;
			gcX_q     <= '0;
			gcY_q     <= '0;
			alpha_q   <= '0;
			layer_q   <= LAYER_RST;
			baseCol_q <= '0;
			cbrdCol_q <= '0;
			vbrdCol_q <= '0;
			gbrdCol_q <= '0;
		end else if (busWr) begin
			unique case (a)
				REG_CTRL:     ctrl_q    <= CTRL_W'(lanes(32'(ctrl_q),
					wb_dat_i, wb_sel_i));
				REG_LINE_PIXEL_TOTAL:   htot_q    <= lanes(htot_q, wb_dat_i, wb_sel_i);
				REG_FRAME_LINE_TOTAL:   vtot_q    <= lanes(vtot_q, wb_dat_i, wb_sel_i);
				REG_HSYNC:    hsyn_q    <= lanes(hsyn_q, wb_dat_i, wb_sel_i);
				REG_VSYNC:    vsyn_q    <= lanes(vsyn_q, wb_dat_i, wb_sel_i);
				REG_VID_X:    vidX_q    <= lanes(vidX_q, wb_dat_i, wb_sel_i);
				REG_VID_Y:    vidY_q    <= lanes(vidY_q, wb_dat_i, wb_sel_i);
				REG_GFX_X:    gfxX_q    <= lanes(gfxX_q, wb_dat_i, wb_sel_i);
				REG_GFX_Y:    gfxY_q    <= lanes(gfxY_q, wb_dat_i, wb_sel_i);
				REG_VCROP_X:  vcX_q     <= lanes(vcX_q, wb_dat_i, wb_sel_i);
				REG_VCROP_Y:  vcY_q     <= lanes(vcY_q, wb_dat_i, wb_sel_i);
				REG_GCROP_X:  gcX_q     <= lanes(gcX_q, wb_dat_i, wb_sel_i);
				REG_GCROP_Y:  gcY_q     <= lanes(gcY_q, wb_dat_i, wb_sel_i);
				REG_ALPHA:    alpha_q   <= lanes(alpha_q, wb_dat_i, wb_sel_i);
				REG_LAYER:    layer_q   <= lanes(layer_q, wb_dat_i, wb_sel_i);
				REG_BASE_COL: baseCol_q <= lanes(baseCol_q, wb_dat_i,
					wb_sel_i);
				REG_CBRD_COL: cbrdCol_q <= lanes(cbrdCol_q, wb_dat_i,
					wb_sel_i);
				REG_VBRD_COL: vbrdCol_q <= lanes(vbrdCol_q, wb_dat_i,
					wb_sel_i);
				REG_GBRD_COL: gbrdCol_q <= lanes(gbrdCol_q, wb_dat_i,
					wb_sel_i);
				default: ;  // unmapped writes are dropped but acked
			endcase
		end
	end

	// ----------------------------------------------------------------
	// timing generator
	// ----------------------------------------------------------------
	logic [CW-1:0] hCnt, vCnt;
	logic          hSync, vSync;

	otu_timing u_timing (
		.sys_clk    (sys_clk),
		.rstn       (rstn),
		.enable     (ctrl_q[CTRL_EN]),
		.lineTotal  (htot_q[CW-1:0]),
		.frameTotal (vtot_q[CW-1:0]),
		.hsStart    (lo(hsyn_q)),
		.hsEnd      (hi(hsyn_q)),
		.vsStart    (lo(vsyn_q)),
		.vsEnd      (hi(vsyn_q)),
		.hCnt       (hCnt),
		.vCnt       (vCnt),
		.hSync      (hSync),
		.vSync      (vSync)
	);

	// status word: raster position and sync state, read only
	wire logic [31:0] statusWord = {2'b00, vSync, hSync, vCnt,
		4'h0, hCnt};

	// read mux; unmapped offsets read as zero
	wire logic [31:0] rdMux =
		(a == REG_CTRL)     ? 32'(ctrl_q)  :
		(a == REG_LINE_PIXEL_TOTAL)   ? htot_q       :
		(a == REG_FRAME_LINE_TOTAL)   ? vtot_q       :
		(a == REG_HSYNC)    ? hsyn_q       :
		(a == REG_VSYNC)    ? vsyn_q       :
		(a == REG_VID_X)    ? vidX_q       :
		(a == REG_VID_Y)    ? vidY_q       :
		(a == REG_GFX_X)    ? gfxX_q       :
		(a == REG_GFX_Y)    ? gfxY_q       :
		(a == REG_VCROP_X)  ? vcX_q        :
		(a == REG_VCROP_Y)  ? vcY_q        :
		(a == REG_GCROP_X)  ? gcX_q        :
		(a == REG_GCROP_Y)  ? gcY_q        :
		(a == REG_ALPHA)    ? alpha_q      :
		(a == REG_LAYER)    ? layer_q      :
		(a == REG_BASE_COL) ? baseCol_q    :
		(a == REG_CBRD_COL) ? cbrdCol_q    :
		(a == REG_VBRD_COL) ? vbrdCol_q    :
		(a == REG_GBRD_COL) ? gbrdCol_q    :
		(a == REG_STATUS)   ? statusWord   : BUS_ERRVAL;

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn)
			rdat_q <= '0;
		else if (busReq)
			rdat_q <= rdMux;
	end

	assign wb_dat_o = rdat_q;
	assign wb_ack_o = ack_q;

	// ----------------------------------------------------------------
	// plane windows and cropping
	// ----------------------------------------------------------------
	// inclusive window test on the raster counters
	function automatic logic inWin(input logic [CW-1:0] x,
		input logic [CW-1:0] y, input logic [31:0] wx,
		input logic [31:0] wy);
		inWin = (x >= lo(wx)) && (x <= hi(wx)) &&
			(y >= lo(wy)) && (y <= hi(wy));
	endfunction

	// canvas: the whole line, 0 to line total minus one, border on the raster edge pixels
	wire logic [31:0] canvasX = {4'h0, htot_q[CW-1:0] - 12'h001,
		16'h0000};
	// requests stop at the blanking pixel, so the pipe is never asked
	// for a pixel that the output stage would throw away
	wire logic active  = (hCnt < hi(canvasX)) &&
		ctrl_q[CTRL_EN];
	wire logic vidWin  = inWin(hCnt, vCnt, vidX_q, vidY_q);
	wire logic gfxWin  = inWin(hCnt, vCnt, gfxX_q, gfxY_q);
	// crop narrows the visible part inside the window
	wire logic vidShow = vidWin && inWin(hCnt, vCnt, vcX_q, vcY_q);
	wire logic gfxShow = gfxWin && inWin(hCnt, vCnt, gcX_q, gcY_q);

	// pixel requests follow the window so the pipe streams in raster order
	assign vidReq = active && vidWin;
	assign gfxReq = active && gfxWin;

	// ----------------------------------------------------------------
	// plane sources: pipe pixel over its solid border, no blending
	// ----------------------------------------------------------------
	wire logic [PW-1:0] vidSrc = vidShow ? vidPix :
		{vbrdCol_q, 4'h0};
	wire logic [PW-1:0] gfxSrc = gfxShow ? gfxPix :
		{gbrdCol_q, 4'h0};
	// alpha: gfx per pixel or global, video always global
	wire logic [AW-1:0] gfxA = !gfxShow ? alpha_q[A_GBRD +: AW] :
		(ctrl_q[CTRL_GFX_PPA] ? gfxAlpha : alpha_q[A_GFX +: AW]);
	wire logic [AW-1:0] vidA = vidShow ? alpha_q[A_VID +: AW] :
		alpha_q[A_VBRD +: AW];

	// base layer with canvas border at the raster edge
	wire logic edgePix = (hCnt == 12'h000) || (hCnt == hi(canvasX)) ||
		(vCnt == 12'h000) || (vCnt == vtot_q[CW-1:0] - 12'h001);
	wire logic [PW-1:0] basePix = edgePix ? {cbrdCol_q, 4'h0} :
		{baseCol_q, 4'h0};

	// ----------------------------------------------------------------
	// layer routing and blend chain
	// ----------------------------------------------------------------
	logic [PW-1:0] layPix [3];
	logic [AW-1:0] layA   [3];
	logic          layOn  [3];
	logic [PW-1:0] chain  [4];

	// any plane to any layer; code 7 (or unknown) leaves layer empty
	always_comb begin
		for (int l = 0; l < 3; l++) begin
			unique case (layer_q[l*LSEL_STRIDE +: LSEL_W])
				OTU_SEL_VID: begin
					layPix[l] = vidSrc;
					layA[l]   = vidA;
					layOn[l]  = vidWin;
				end
				OTU_SEL_GFX: begin
					layPix[l] = gfxSrc;
					layA[l]   = gfxA;
					layOn[l]  = gfxWin;
				end
				default: begin
					layPix[l] = '0;
					layA[l]   = '0;
					layOn[l]  = 1'b0;
				end
			endcase
		end
	end

	assign chain[0] = basePix;

	// layer 1 lowest, layer 3 on top; pixels stay in ipt or rgb
	for (genvar l = 0; l < 3; l++) begin : g_layer
		otu_blend u_blend (
			.fgPix    (layPix[l]),
			.bgPix    (chain[l]),
			.alpha    (layA[l]),
			.fgValid  (layOn[l]),
			.invSense (ctrl_q[CTRL_INV]),
			.preMul   (ctrl_q[CTRL_PREMUL]),
			.outPix   (chain[l+1])
		);
	end

	// ----------------------------------------------------------------
	// output stage: registered, one transmitter at a time
	// ----------------------------------------------------------------
	logic [PW-1:0] outPix_q;
	logic          outDe_q, outHs_q, outVs_q, dest_q;

	wire logic inActive = (hCnt < hi(canvasX)) && ctrl_q[CTRL_EN];

	// forward blended data with its sync, one cycle behind the raster
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			outPix_q <= '0;
			outDe_q  <= 1'b0;
			outHs_q  <= 1'b0;
			outVs_q  <= 1'b0;
			dest_q   <= 1'b0;
		end else begin
			outPix_q <= chain[3];
			outDe_q  <= inActive;
			outHs_q  <= hSync;
			outVs_q  <= vSync;
			dest_q   <= ctrl_q[CTRL_DEST];
		end
	end

	// the idle port sees zeros, so both sinks never run together
	assign hdmiPix = dest_q ? '0 : outPix_q;
	assign hdmiDe  = !dest_q && outDe_q;
	assign hdmiHs  = !dest_q && outHs_q;
	assign hdmiVs  = !dest_q && outVs_q;
	assign mipiPix = dest_q ? outPix_q : '0;
	assign mipiDe  = dest_q && outDe_q;
	assign mipiHs  = dest_q && outHs_q;
	assign mipiVs  = dest_q && outVs_q;

endmodule

`default_nettype wire

// *** hw/otu_pkg.sv ***
/*
 * otu_pkg: register map, field positions, reset values and enumerations
 * shared by the overlay timing unit and its helpers.
 * Assumes a 32-bit classic Wishbone register bus with byte addressing.
 */
`default_nettype none

package otu_pkg;

	// ----------------------------------------------------------------
	// widths
	// ----------------------------------------------------------------
	localparam int CW          = 12;    // counter / position width
	localparam int PW          = 36;    // pixel width, 3 x 12 bpc
	localparam int AW          = 8;     // alpha width

	// ----------------------------------------------------------------
	// register byte offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] REG_CTRL      = 8'h00;
	localparam logic [7:0] REG_LINE_PIXEL_TOTAL    = 8'h04;
	localparam logic [7:0] REG_FRAME_LINE_TOTAL    = 8'h08;
	localparam logic [7:0] REG_HSYNC     = 8'h0C;
	localparam logic [7:0] REG_VSYNC     = 8'h10;
	localparam logic [7:0] REG_VID_X     = 8'h14;
	localparam logic [7:0] REG_VID_Y     = 8'h18;
	localparam logic [7:0] REG_GFX_X     = 8'h1C;
	localparam logic [7:0] REG_GFX_Y     = 8'h20;
	localparam logic [7:0] REG_VCROP_X   = 8'h24;
	localparam logic [7:0] REG_VCROP_Y   = 8'h28;
	localparam logic [7:0] REG_GCROP_X   = 8'h2C;
	localparam logic [7:0] REG_GCROP_Y   = 8'h30;
	localparam logic [7:0] REG_ALPHA     = 8'h34;
	localparam logic [7:0] REG_LAYER     = 8'h38;
	localparam logic [7:0] REG_BASE_COL  = 8'h3C;
	localparam logic [7:0] REG_CBRD_COL  = 8'h40;
	localparam logic [7:0] REG_VBRD_COL  = 8'h44;
	localparam logic [7:0] REG_GBRD_COL  = 8'h48;
	localparam logic [7:0] REG_STATUS    = 8'h4C;

	// ----------------------------------------------------------------
	// control fields
	// ----------------------------------------------------------------
	localparam int CTRL_EN       = 0;   // timing generator run
	localparam int CTRL_GFX_PPA  = 1;   // graphics per-pixel alpha
	localparam int CTRL_INV      = 2;   // inverted alpha sense
	localparam int CTRL_PREMUL   = 3;   // premultiplied blending
	localparam int CTRL_DEST     = 4;   // 0 hdmi, 1 mipi
	localparam int CTRL_W        = 5;

	// fields packed in pairs: start in [11:0], end in [27:16]
	localparam int LO_POS = 0;
	localparam int HI_POS = 16;

	// alpha register: video [7:0], gfx [15:8], vbrd [23:16], gbrd [31:24]
	localparam int A_VID  = 0;
	localparam int A_GFX  = 8;
	localparam int A_VBRD = 16;
	localparam int A_GBRD = 24;

	// layer selector: layer1 [2:0], layer2 [6:4], layer3 [10:8]
	localparam int LSEL_W      = 3;
	localparam int LSEL_STRIDE = 4;

	// ----------------------------------------------------------------
	// reset values (small 640x480-like frame)
	// ----------------------------------------------------------------
	localparam logic [CW-1:0] LINE_PIXEL_TOTAL_RST = 12'h320;
	localparam logic [CW-1:0] FRAME_LINE_TOTAL_RST = 12'h20D;
	localparam logic [31:0]   LAYER_RST  = 32'h0000_0777;
	localparam logic [31:0]   BUS_ERRVAL = 32'h0000_0000;

	// plane codes for the layer selectors
	typedef enum logic [LSEL_W-1:0] {
		OTU_SEL_VID   = 3'h1,
		OTU_SEL_GFX   = 3'h3,
		OTU_SEL_OFF   = 3'h7
	} otu_sel_t;

endpackage

`default_nettype wire

// *** hw/otu_blend.sv ***
/*
 * otu_blend: one alpha blender stage, combinational.
 * Assumes three 12-bit components per pixel and an 8-bit alpha where
 * 8'hFF stands for one.
 */
`default_nettype none

module otu_blend
	import otu_pkg::*;
(
	// operands
	input  wire logic [PW-1:0] fgPix,
	input  wire logic [PW-1:0] bgPix,
	input  wire logic [AW-1:0] alpha,
	input  wire logic          fgValid,
	// mode
	input  wire logic          invSense,
	input  wire logic          preMul,
	// result
	output logic      [PW-1:0] outPix
);

	// ----------------------------------------------------------------
	// per component arithmetic
	// ----------------------------------------------------------------
	function automatic logic [11:0] mix(input logic [11:0] a,
		input logic [11:0] b, input logic [7:0] ka, input logic [7:0] kb);
		logic [20:0] s;
		s = 21'(a * ka) + 21'(b * kb);
		mix = 12'(s / 21'd255);
	endfunction

	function automatic logic [11:0] addsat(input logic [11:0] a,
		input logic [11:0] b, input logic [7:0] kb);
		logic [20:0] s;
		s = 21'(a) + 21'(21'(b * kb) / 21'd255);
		addsat = (s > 21'h000FFF) ? 12'hFFF : s[11:0];
	endfunction

	wire logic [AW-1:0] alphaInv = 8'hFF - alpha;
	// weights of fg and bg follow the sense
	wire logic [AW-1:0] kFg = invSense ? alphaInv : alpha;
	wire logic [AW-1:0] kBg = invSense ? alpha : alphaInv;

	logic [PW-1:0] blended;

	// normal and premultiplied equations, both senses
	always_comb begin
		for (int i = 0; i < 3; i++) begin
			if (preMul) begin
				blended[i*12 +: 12] = addsat(fgPix[i*12 +: 12],
					bgPix[i*12 +: 12], kBg);
			end else begin
				blended[i*12 +: 12] = mix(fgPix[i*12 +: 12],
					bgPix[i*12 +: 12], kFg, kBg);
			end
		end
	end

	// a layer that covers nothing here passes the background unchanged
	assign outPix = fgValid ? blended : bgPix;

endmodule

`default_nettype wire

// *** hw/otu_timing.sv ***
/*
 * otu_timing: raster counters and sync generation.
 * Assumes totals of at least 2 and sync positions below the totals.
 */
`default_nettype none

module otu_timing
	import otu_pkg::*;
(
	// clock and reset
	input  wire logic          sys_clk,
	input  wire logic          rstn,
	// settings
	input  wire logic          enable,
	input  wire logic [CW-1:0] lineTotal,
	input  wire logic [CW-1:0] frameTotal,
	input  wire logic [CW-1:0] hsStart,
	input  wire logic [CW-1:0] hsEnd,
	input  wire logic [CW-1:0] vsStart,
	input  wire logic [CW-1:0] vsEnd,
	// raster
	output logic      [CW-1:0] hCnt,
	output logic      [CW-1:0] vCnt,
	output logic               hSync,
	output logic               vSync
);

	logic [CW-1:0] hCnt_q;
	logic [CW-1:0] vCnt_q;
	logic          hs_q;
	logic          vs_q;

	wire logic lineEnd  = (hCnt_q >= lineTotal - 12'h001);
	wire logic frameEnd = (vCnt_q >= frameTotal - 12'h001);
	wire logic [CW-1:0] hCnt_d = lineEnd ? '0 : hCnt_q + 12'h001;
	wire logic [CW-1:0] vCnt_d = !lineEnd ? vCnt_q :
		(frameEnd ? '0 : vCnt_q + 12'h001);

	// ----------------------------------------------------------------
	// counters wrap to zero at total minus one
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			hCnt_q <= '0;
			vCnt_q <= '0;
		end else if (!enable) begin
			hCnt_q <= '0;
			vCnt_q <= '0;
		end else begin
			hCnt_q <= hCnt_d;   // line length = line total
			vCnt_q <= vCnt_d;   // frame height = frame total
		end
	end

	// sync flags set and cleared at the programmed positions
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			hs_q <= 1'b0;
			vs_q <= 1'b0;
		end else if (!enable) begin
			hs_q <= 1'b0;
			vs_q <= 1'b0;
		end else begin
			if (hCnt_d == hsStart)
				hs_q <= 1'b1;
			else if (hCnt_d == hsEnd)
				hs_q <= 1'b0;
			if (lineEnd && vCnt_d == vsStart)
				vs_q <= 1'b1;
			else if (lineEnd && vCnt_d == vsEnd)
				vs_q <= 1'b0;
		end
	end

	assign hCnt  = hCnt_q;
	assign vCnt  = vCnt_q;
	assign hSync = hs_q;
	assign vSync = vs_q;

endmodule

`default_nettype wire

// *** tb/otu_monitor.sv ***
/* otu_monitor: port-level assertions for otu_top.
   Assumes one clock domain and an active-low asynchronous reset. */
`default_nettype none
module otu_monitor
	import otu_pkg::*;
(
	// clock, reset and register bus
	input wire logic          sys_clk,
	input wire logic          rstn,
	input wire logic          wb_cyc_i,
	input wire logic          wb_stb_i,
	input wire logic          wb_we_i,
	input wire logic [7:0]    wb_adr_i,
	input wire logic [31:0]   wb_dat_o,
	input wire logic          wb_ack_o,
	// transmitter ports
	input wire logic [PW-1:0] hdmiPix,
	input wire logic          hdmiDe,
	input wire logic          hdmiHs,
	input wire logic          hdmiVs,
	input wire logic [PW-1:0] mipiPix,
	input wire logic          mipiDe,
	input wire logic          mipiHs,
	input wire logic          mipiVs
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rstn);
	// a port counts as live while any of its timing lines is up
	wire logic hdmiOn = hdmiDe || hdmiHs || hdmiVs;
	wire logic mipiOn = mipiDe || mipiHs || mipiVs;
	// bus request still waiting for its answer
	sequence busWait;
		wb_cyc_i && wb_stb_i && !wb_ack_o;
	endsequence
	chk_ack_next: assert property (busWait |=> wb_ack_o)
		else $error("bus request not answered");
	chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held over one cycle");
	chk_ack_cause: assert property ($rose(wb_ack_o) |-> $past(wb_stb_i))
		else $error("ack without request");
	chk_null_read: assert property (wb_ack_o && !wb_we_i &&
		wb_adr_i >= 8'h50 |-> wb_dat_o == 32'h0)
		else $error("unmapped read not zero");
	chk_one_port: assert property (!(hdmiOn && mipiOn))
		else $error("both transmitters active");
	chk_hdmi_idle: assert property (mipiOn |-> hdmiPix == '0)
		else $error("idle hdmi pixel not zero");
	chk_mipi_idle: assert property (hdmiOn |-> mipiPix == '0)
		else $error("idle mipi pixel not zero");
	chk_vs_wrap: assert property ($rose(hdmiVs) |-> !$past(hdmiDe))
		else $error("vsync rose away from line wrap");
endmodule
bind otu_top otu_monitor u_mon (
	.sys_clk(sys_clk), .rstn(rstn), .wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
	.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .hdmiPix(hdmiPix),
	.hdmiDe(hdmiDe), .hdmiHs(hdmiHs), .hdmiVs(hdmiVs), .mipiPix(mipiPix),
	.mipiDe(mipiDe), .mipiHs(mipiHs), .mipiVs(mipiVs)
);
`default_nettype wire

// *** tb/otu_pipe_model.sv ***
/* otu_pipe_model: upstream pipe answering the plane pixel requests.
   Assumes requests are combinational and answered in the same cycle. */
`default_nettype none
module otu_pipe_model
	import otu_pkg::*;
#(
	parameter logic [PW-1:0] VID_COL = 36'hABC123456,
	parameter logic [PW-1:0] GFX_COL = 36'h0F00F00F0
)
(
	// clock and requests
	input  wire logic          sys_clk,
	input  wire logic          vidReq,
	input  wire logic          gfxReq,
	// answers
	output logic      [PW-1:0] vidPix,
	output logic      [PW-1:0] gfxPix,
	output logic      [AW-1:0] gfxAlpha
);
	timeunit 1ns;
	timeprecision 1ps;
	logic tgl_q = 1'b0;
	// idle lines toggle so stale data is never taken for an answer
	always_ff @(posedge sys_clk) begin
		tgl_q <= ~tgl_q;
	end
	// same-cycle answer while a request stands
	assign vidPix   = vidReq ? VID_COL : {PW{tgl_q}};
	assign gfxPix   = gfxReq ? GFX_COL : {PW{tgl_q}};
	assign gfxAlpha = gfxReq ? 8'hFF : {AW{tgl_q}};
endmodule
`default_nettype wire

// *** tb/overlay_blender_timing_gen_bench.sv ***
/* overlay_blender_timing_gen_bench: self-checking bench for otu_top.
   Assumes otu_pipe_model on the plane streams and otu_monitor bound. */
`default_nettype none
module overlay_blender_timing_gen_bench
	import otu_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin fails++; \
	$display("mismatch %0t got %h exp %h", $time, a, e); end end
	typedef struct packed {
		logic [31:0]   ctrl;
		logic [31:0]   alpha;
		logic [31:0]   layer;
		logic [PW-1:0] pix;
	} otu_row_t;
	localparam logic [PW-1:0] BASE = 36'h123456780;
	localparam logic [PW-1:0] VID  = 36'hABC123456;
	localparam logic [PW-1:0] GFX  = 36'h0F00F00F0;
	localparam logic [PW-1:0] SUM  = 36'hBDF579BD6;
	// control, alpha, layer order and the pixel seen mid-canvas
	localparam otu_row_t ROWS [10] = '{
		'{32'h01, 32'h00, 32'h777, BASE}, '{32'h01, 32'hFF, 32'h771, VID},
		'{32'h05, 32'hFF, 32'h771, BASE}, '{32'h09, 32'h00, 32'h771, SUM},
		'{32'h0D, 32'hFF, 32'h771, SUM}, '{32'h01, 32'hFF, 32'h717, VID},
		'{32'h03, 32'h00, 32'h773, GFX}, '{32'h01, 32'h00, 32'h773, BASE},
		'{32'h03, 32'hFF, 32'h731, GFX}, '{32'h11, 32'hFF, 32'h771, VID}};
	logic               sys_clk  = 1'b0;
	logic               rstn     = 1'b0;
	logic               wb_cyc_i = 1'b0;
	logic               wb_stb_i = 1'b0;
	logic               wb_we_i  = 1'b0;
	logic [7:0]         wb_adr_i = 8'h00;
	logic [31:0]        wb_dat_i = 32'h0;
	logic [31:0]        rd;
	logic               dst      = 1'b0;
	int                 fails    = 0;
	int                 comparisons = 0;
	int                 n;
	wire logic [31:0]   wb_dat_o;
	wire logic          wb_ack_o, vidReq, gfxReq;
	wire logic          hdmiDe, hdmiHs, hdmiVs, mipiDe, mipiHs, mipiVs;
	wire logic [PW-1:0] vidPix, gfxPix, hdmiPix, mipiPix;
	wire logic [AW-1:0] gfxAlpha;
	// the port under observation follows the programmed destination
	wire logic          sHs  = dst ? mipiHs : hdmiHs;
	wire logic          sVs  = dst ? mipiVs : hdmiVs;
	wire logic [PW-1:0] sPix = dst ? mipiPix : hdmiPix;
	wire logic          sDe  = dst ? mipiDe : hdmiDe;
	initial begin
		forever #2 sys_clk = ~sys_clk;
	end
	otu_top u_dut (.sys_clk(sys_clk), .rstn(rstn), .wb_cyc_i(wb_cyc_i),
		.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
		.wb_sel_i(4'hF), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o), .vidReq(vidReq), .vidPix(vidPix),
		.gfxReq(gfxReq), .gfxPix(gfxPix), .gfxAlpha(gfxAlpha),
		.hdmiPix(hdmiPix), .hdmiDe(hdmiDe), .hdmiHs(hdmiHs),
		.hdmiVs(hdmiVs), .mipiPix(mipiPix), .mipiDe(mipiDe),
		.mipiHs(mipiHs), .mipiVs(mipiVs));
	otu_pipe_model u_pipe (.sys_clk(sys_clk), .vidReq(vidReq),
		.gfxReq(gfxReq), .vidPix(vidPix), .gfxPix(gfxPix),
		.gfxAlpha(gfxAlpha));
	// one classic cycle; the request stands until ack is sampled
	task automatic wb(input logic we, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge sys_clk);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i  <= we;
		wb_adr_i <= a;
		wb_dat_i <= d;
		do begin
			@(posedge sys_clk);
		end while (wb_ack_o !== 1'b1);
		rd = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask
	// wait while the chosen sync sits at a level, counting cycles
	task automatic hold(input logic lvl, input logic v);
		while ((v ? sVs : sHs) === lvl && n < 300) begin
			@(posedge sys_clk);
			#1;
			n++;
		end
	endtask
	// width and period of a sync pulse, rise to rise
	task automatic meas(input logic v, input int ew, input int ep);
		n = 0;
		hold(1'b1, v);
		hold(1'b0, v);
		n = 0;
		hold(1'b1, v);
		`CHK(n, ew)
		hold(1'b0, v);
		`CHK(n, ep)
	endtask
	// park on the first hsync pixel of the line after vsync falls
	task automatic mid;
		n = 0;
		hold(1'b0, 1'b1);
		hold(1'b1, 1'b1);
		hold(1'b0, 1'b0);
	endtask
	task report_and_stop;
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	// a 10 x 6 raster keeps every frame short
	initial begin
		repeat (16) @(posedge sys_clk);
		rstn <= 1'b1;
		#1;
		`CHK({hdmiDe, hdmiHs, hdmiVs, mipiDe, wb_ack_o}, 5'h00)
		wb(1'b0, REG_LAYER, 32'h0);
		`CHK(rd, LAYER_RST)
		wb(1'b1, 8'h50, 32'hFFFF_FFFF);
		wb(1'b0, 8'h50, 32'h0);
		`CHK(rd, 32'h0)
		wb(1'b1, REG_LINE_PIXEL_TOTAL, 32'hA);
		wb(1'b1, REG_FRAME_LINE_TOTAL, 32'h6);
		wb(1'b1, REG_HSYNC, 32'h0005_0002);
		wb(1'b1, REG_VSYNC, 32'h0003_0001);
		wb(1'b1, REG_BASE_COL, 32'h1234_5678);
		for (int a = 20; a <= 44; a += 8) begin
			wb(1'b1, 8'(a), 32'h0009_0000);
			wb(1'b1, 8'(a + 4), 32'h0005_0000);
		end
		wb(1'b1, REG_CTRL, 32'h1);
		meas(1'b0, 3, 10);
		meas(1'b1, 20, 60);
		foreach (ROWS[i]) begin
			wb(1'b1, REG_CTRL, ROWS[i].ctrl);
			wb(1'b1, REG_ALPHA, ROWS[i].alpha);
			wb(1'b1, REG_LAYER, ROWS[i].layer);
			dst = ROWS[i].ctrl[CTRL_DEST];
			mid();
			`CHK(sPix, ROWS[i].pix)
			`CHK(sDe, 1'b1)
		end
		meas(1'b0, 3, 10);
		meas(1'b1, 20, 60);
		`CHK(hdmiPix, 36'h0)
		// crop the video plane to start right of the probe pixel: its border shows
		wb(1'b1, REG_VCROP_X, 32'h0009_0004);
		wb(1'b1, REG_VBRD_COL, 32'h0ABC_DEF0);
		wb(1'b1, REG_ALPHA, 32'h00FF_00FF);
		mid();
		`CHK(sPix, 36'h0ABCDEF00)
		report_and_stop;
	end
	// whole run is about a thousand cycles
	initial begin
		#100000;
		fails++;
		report_and_stop;
	end
endmodule
`default_nettype wire
